// ===== hw/lock_cmd_pkg.sv
`default_nettype none

package lock_cmd_pkg;

	// ****************************************
	// Command codes and frame layout
	// ****************************************
	localparam logic [5:0] CMD_LOCK_BLOCKS = 6'h12;
	localparam logic [5:0] CMD_WRITE_MULTI = 6'h11;
	localparam int HDR_BITS = 16;
	localparam int UID_BITS = 40;
	localparam int LOCK_DATA_BITS = 32;
	localparam int CRC16_BITS = 16;
	localparam logic [7:0] BODY_START_NO_UID = 8'h10;
	localparam logic [7:0] BODY_START_UID = 8'h38;
	localparam logic [7:0] FRAME_LEN_NO_UID = 8'h40;
	localparam logic [7:0] FRAME_LEN_UID = 8'h68;
	localparam logic [7:0] CNT_MAX = 8'hFF;

	// ****************************************
	// Header field positions, first bit on air at the top
	// ****************************************
	localparam int HDR_EXT_POS = 15;
	localparam int HDR_CMD_MSB = 14;
	localparam int HDR_CMD_LSB = 9;
	localparam int HDR_FLAG_POS = 8;
	localparam int HDR_AREA_MSB = 7;
	localparam int HDR_AREA_LSB = 5;

	// ****************************************
	// Lock storage geometry
	// ****************************************
	localparam int NUM_AREAS = 8;
	localparam int AREA_IDX_BITS = 3;
	localparam int AREA_BITS = 32;
	localparam int BLOCK_IDX_BITS = 8;
	localparam logic [AREA_BITS-1:0] AREA_ERASED = 32'h0000_0000;

	// ****************************************
	// Answer codes and reset values
	// ****************************************
	localparam logic [7:0] ERR_NOT_SUPPORTED = 8'h01;
	localparam logic [7:0] ERR_LOCK_FAILED = 8'h0F;
	localparam logic [7:0] ERR_NONE = 8'h00;

	// ****************************************
	// Tag states seen by this block
	// ****************************************
	typedef enum logic [2:0] {
		TAG_READY,
		TAG_QUIET,
		TAG_SELECTED,
		TAG_ROUND_ACTIVE,
		TAG_ROUND_STANDBY
	} tag_state_e;

endpackage : lock_cmd_pkg

`default_nettype wire

// ===== hw/lock_area_store.sv
`timescale 1ns/1ns
`default_nettype none

module lock_area_store #(
	parameter int AREAS = lock_cmd_pkg::NUM_AREAS,
	parameter int WIDTH = lock_cmd_pkg::AREA_BITS,
	parameter int IDX_W = lock_cmd_pkg::AREA_IDX_BITS
) (
	// Clock
	input wire logic clk,
	// Set-only write port
	input wire logic wr_en,
	input wire logic [IDX_W-1:0] wr_idx,
	input wire logic [WIDTH-1:0] wr_bits,
	// Registered read port
	input wire logic [IDX_W-1:0] rd_idx,
	output logic [WIDTH-1:0] rd_data_q
);

	// ****************************************
	// Areas model non-volatile cells: no reset
	// ****************************************
	logic [WIDTH-1:0] area_q [AREAS];

	for (genvar i = 0; i < AREAS; i++) begin : g_area
		initial begin
			area_q[i] = lock_cmd_pkg::AREA_ERASED; // [R16]
		end
		always_ff @(posedge clk) begin
			if (wr_en && wr_idx == IDX_W'(i)) begin
				area_q[i] <= area_q[i] | wr_bits; // [R8] [R6]
			end
		end
	end

	always_ff @(posedge clk) begin
		rd_data_q <= area_q[rd_idx];
	end

endmodule : lock_area_store

`default_nettype wire

// ===== hw/tag_block_lock_command_handler.sv
// How it works
// R1 - Command code 12, once accepted, permanently locks the requested blocks.
// R2 - Lock information is held as 32-bit areas, one bit per user block.
// R3 - Area bit 0 is the area's lowest block; higher bits, higher blocks.
// R4 - A 3-bit index picks one of eight areas; only that area is written.
// R5 - Eight areas of 32 bits track all 256 blocks.
// R6 - A set bit in the lock data marks its block locked.
// R7 - Reader sends zero for every block it does not want locked.
// R8 - Lock bits are set-only; a later zero never clears one.
// R9 - Frame: ext, code, flag, index, CRC-5, optional ID, data, CRC-16.
// R10 - Addressed but unsupported: answer error flag with error code 1.
// R11 - Addressed and supported: error-form answer on failure, else success.
// R12 - Neither selected nor matched by ID: send nothing.
// R13 - Ready, Quiet and round states act only on a matching ID.
// R14 - Selected acts on flag 0 or matching ID; mismatch does nothing.
// R15 - Multi-block write uses the same addressing and never changes state.
// R16 - Lock areas are non-volatile; reset never clears a set bit.
`timescale 1ns/1ns
`default_nettype none

module tag_block_lock_command_handler #(
	parameter bit LOCK_SUPPORTED = 1'b1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Demodulated frame bits, same clock domain
	input wire logic rx_bit_valid,
	input wire logic rx_bit,
	input wire logic rx_frame_end,
	// Checks from the CRC unit
	input wire logic crc5_ok,
	input wire logic crc16_ok,
	// Tag context
	input wire logic [39:0] tag_unique_identifier,
	input wire lock_cmd_pkg::tag_state_e tag_state,
	input wire logic nvm_fail,
	// Answer to the reader
	output logic resp_valid,
	output logic resp_error_flag,
	output logic [7:0] resp_error_code,
	// Multi-block write addressing
	output logic mbw_grant,
	output logic [7:0] mbw_header_bits,
	// Lock bit query
	input wire logic query_valid,
	input wire logic [7:0] query_block,
	output logic query_done,
	output logic query_locked,
	output logic [31:0] query_area_bits
);

	// ****************************************
	// Receive state
	// ****************************************
	typedef enum logic [1:0] {
		ST_HDR,
		ST_BODY,
		ST_SKIP,
		ST_WRITE
	} rx_state_e;

	rx_state_e state_q;
	rx_state_e state_d;
	logic [7:0] cnt_q;
	logic [15:0] hdr_q;
	logic [39:0] uid_q;
	logic [31:0] data_q;
	logic decided_q;
	logic is_lock_q;
	logic resp_valid_q;
	logic resp_error_flag_q;
	logic [7:0] resp_error_code_q;
	logic mbw_grant_q;
	logic [7:0] mbw_header_q;

	logic hdr_complete;
	logic hdr_bad;
	logic id_flag;
	logic [5:0] cmd_code;
	logic [2:0] area_idx;
	logic [7:0] body_start;
	logic [7:0] frame_len;
	logic id_match;
	logic addressed;
	logic decide_now;
	logic frame_good;
	logic in_uid;
	logic in_data;
	logic store_wr;

	// ****************************************
	// Header fields
	// ****************************************
	assign id_flag = hdr_q[lock_cmd_pkg::HDR_FLAG_POS];
	assign cmd_code = hdr_q[lock_cmd_pkg::HDR_CMD_MSB:lock_cmd_pkg::HDR_CMD_LSB];
	assign area_idx = hdr_q[lock_cmd_pkg::HDR_AREA_MSB:
		lock_cmd_pkg::HDR_AREA_LSB]; // [R4]
	assign hdr_complete = (cnt_q == lock_cmd_pkg::BODY_START_NO_UID);
	// Foreign command, extended set, or broken header
	assign hdr_bad = !crc5_ok
		|| hdr_q[lock_cmd_pkg::HDR_EXT_POS]
		|| (cmd_code != lock_cmd_pkg::CMD_LOCK_BLOCKS
		&& cmd_code != lock_cmd_pkg::CMD_WRITE_MULTI);

	// ****************************************
	// Frame geometry
	// ****************************************
	assign body_start = id_flag ? lock_cmd_pkg::BODY_START_UID
		: lock_cmd_pkg::BODY_START_NO_UID; // [R9]
	assign frame_len = id_flag ? lock_cmd_pkg::FRAME_LEN_UID
		: lock_cmd_pkg::FRAME_LEN_NO_UID; // [R9]
	assign in_uid = id_flag && cnt_q >= lock_cmd_pkg::BODY_START_NO_UID
		&& cnt_q < lock_cmd_pkg::BODY_START_UID; // [R9]
	assign in_data = cnt_q >= body_start
		&& cnt_q < body_start + 8'(lock_cmd_pkg::LOCK_DATA_BITS); // [R9]

	// ****************************************
	// Addressing
	// ****************************************
	assign id_match = id_flag && (uid_q == tag_unique_identifier);
	always_comb begin
		unique case (tag_state)
			lock_cmd_pkg::TAG_SELECTED: begin
				addressed = !id_flag || id_match; // [R14]
			end
			lock_cmd_pkg::TAG_READY,
			lock_cmd_pkg::TAG_QUIET,
			lock_cmd_pkg::TAG_ROUND_ACTIVE,
			lock_cmd_pkg::TAG_ROUND_STANDBY: begin
				addressed = id_match; // [R13]
			end
			default: begin
				addressed = 1'b0;
			end
		endcase
	end
	assign decide_now = (state_q == ST_BODY) && !decided_q
		&& (cnt_q >= body_start);
	assign frame_good = decided_q && is_lock_q && crc16_ok
		&& (cnt_q == frame_len); // [R9]

	// ****************************************
	// Receive sequencing
	// ****************************************
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_HDR: begin
				if (hdr_complete) begin
					state_d = hdr_bad ? ST_SKIP : ST_BODY;
				end
			end
			ST_BODY: begin
				if (rx_frame_end) begin
					state_d = frame_good ? ST_WRITE : ST_HDR;
				end else if (decide_now) begin
					if (!addressed) begin
						state_d = ST_SKIP; // [R12]
					end else if (!is_lock_q) begin
						state_d = ST_SKIP; // [R15]
					end
				end
			end
			ST_SKIP: begin
				if (rx_frame_end) begin
					state_d = ST_HDR;
				end
			end
			ST_WRITE: begin
				state_d = ST_HDR;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= ST_HDR;
		end else begin
			state_q <= state_d;
		end
	end

	// ****************************************
	// Bit counter and field capture
	// ****************************************
	always_ff @(posedge clk) begin
		if (reset || rx_frame_end) begin
			cnt_q <= 8'h00;
		end else if (rx_bit_valid && cnt_q != lock_cmd_pkg::CNT_MAX) begin
			cnt_q <= cnt_q + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			hdr_q <= 16'h0000;
		end else if (rx_bit_valid && state_q == ST_HDR && !hdr_complete) begin
			hdr_q <= {hdr_q[14:0], rx_bit}; // [R9]
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			uid_q <= 40'h00_0000_0000;
		end else if (rx_bit_valid && in_uid) begin
			uid_q <= {uid_q[38:0], rx_bit}; // [R9]
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			data_q <= 32'h0000_0000;
		end else if (rx_bit_valid && in_data) begin
			data_q <= {data_q[30:0], rx_bit}; // [R9]
		end
	end

	always_ff @(posedge clk) begin
		if (reset || state_q == ST_HDR) begin
			decided_q <= 1'b0;
		end else if (decide_now) begin
			decided_q <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			is_lock_q <= 1'b0;
		end else if (state_q == ST_HDR && hdr_complete) begin
			is_lock_q <= (cmd_code == lock_cmd_pkg::CMD_LOCK_BLOCKS); // [R1]
		end
	end

	// ****************************************
	// Multi-block write grant
	// ****************************************
	always_ff @(posedge clk) begin
		if (reset) begin
			mbw_grant_q <= 1'b0;
			mbw_header_q <= 8'h00;
		end else begin
			mbw_grant_q <= decide_now && addressed && !is_lock_q; // [R15]
			if (decide_now) begin
				mbw_header_q <= hdr_q[15:8];
			end
		end
	end

	// ****************************************
	// Lock commit and answer
	// ****************************************
	assign store_wr = (state_q == ST_WRITE) && LOCK_SUPPORTED; // [R1]

	always_ff @(posedge clk) begin
		if (reset) begin
			resp_valid_q <= 1'b0;
			resp_error_flag_q <= 1'b0;
			resp_error_code_q <= lock_cmd_pkg::ERR_NONE;
		end else begin
			resp_valid_q <= (state_q == ST_WRITE); // [R12]
			if (state_q == ST_WRITE) begin
				if (!LOCK_SUPPORTED) begin
					resp_error_flag_q <= 1'b1; // [R10]
					resp_error_code_q <= lock_cmd_pkg::ERR_NOT_SUPPORTED; // [R10]
				end else if (nvm_fail) begin
					resp_error_flag_q <= 1'b1; // [R11]
					resp_error_code_q <= lock_cmd_pkg::ERR_LOCK_FAILED; // [R11]
				end else begin
					resp_error_flag_q <= 1'b0; // [R11]
					resp_error_code_q <= lock_cmd_pkg::ERR_NONE; // [R11]
				end
			end
		end
	end

	// ****************************************
	// Lock storage and query
	// ****************************************
	logic [31:0] area_rd;
	logic q_stage1_q;
	logic q_done_q;
	logic [4:0] q_bit_q;
	logic q_locked_q;
	logic [31:0] q_area_q;

	lock_area_store #(
		.AREAS(lock_cmd_pkg::NUM_AREAS),
		.WIDTH(lock_cmd_pkg::AREA_BITS),
		.IDX_W(lock_cmd_pkg::AREA_IDX_BITS)
	) u_store (
		.clk(clk),
		.wr_en(store_wr),
		.wr_idx(area_idx), // [R4] [R5]
		.wr_bits(data_q), // [R2] [R6]
		.rd_idx(query_block[7:5]), // [R5]
		.rd_data_q(area_rd)
	);

	always_ff @(posedge clk) begin
		if (reset) begin
			q_stage1_q <= 1'b0;
			q_done_q <= 1'b0;
			q_bit_q <= 5'h00;
			q_locked_q <= 1'b0;
			q_area_q <= 32'h0000_0000;
		end else begin
			q_stage1_q <= query_valid;
			q_done_q <= q_stage1_q;
			if (query_valid) begin
				q_bit_q <= query_block[4:0];
			end
			if (q_stage1_q) begin
				q_locked_q <= area_rd[q_bit_q]; // [R3]
				q_area_q <= area_rd;
			end
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign resp_valid = resp_valid_q;
	assign resp_error_flag = resp_error_flag_q;
	assign resp_error_code = resp_error_code_q;
	assign mbw_grant = mbw_grant_q;
	assign mbw_header_bits = mbw_header_q;
	assign query_done = q_done_q;
	assign query_locked = q_locked_q;
	assign query_area_bits = q_area_q;

endmodule : tag_block_lock_command_handler

`default_nettype wire

// ===== tb/lock_handler_chk.sv
`timescale 1ns/1ns
`default_nettype none
module lock_handler_chk #(
	parameter bit LOCK_SUPPORTED = 1'b1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Handler inputs
	input wire logic rx_frame_end,
	input wire logic crc16_ok,
	input wire logic nvm_fail,
	input wire logic query_valid,
	input wire logic [7:0] query_block,
	// Handler outputs
	input wire logic resp_valid,
	input wire logic resp_error_flag,
	input wire logic [7:0] resp_error_code,
	input wire logic mbw_grant,
	input wire logic [7:0] mbw_header_bits,
	input wire logic query_done,
	input wire logic query_locked,
	input wire logic [31:0] query_area_bits
);
	logic [4:0] bit1_q;
	logic [4:0] bit2_q;
	always_ff @(posedge clk) begin
		bit1_q <= query_block[4:0];
		bit2_q <= bit1_q;
	end
	// ****
	// Assertions
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	property p_cause;
		resp_valid |-> $past(rx_frame_end, 2) && $past(crc16_ok, 2);
	endproperty
	a_cause: assert property (p_cause)
		else $error("answer without good frame");
	property p_pulse; resp_valid |=> !resp_valid; endproperty
	a_pulse: assert property (p_pulse)
		else $error("answer too long");
	property p_ok;
		LOCK_SUPPORTED && resp_valid && !$past(nvm_fail) |->
			!resp_error_flag && resp_error_code == lock_cmd_pkg::ERR_NONE;
	endproperty
	a_ok: assert property (p_ok) else $error("bad success answer");
	property p_fail;
		LOCK_SUPPORTED && resp_valid && $past(nvm_fail) |->
			resp_error_flag && resp_error_code == lock_cmd_pkg::ERR_LOCK_FAILED;
	endproperty
	a_fail: assert property (p_fail) else $error("bad error answer");
	property p_hold;
		!resp_valid |-> $stable(resp_error_flag) && $stable(resp_error_code)
			|| $past(reset);
	endproperty
	a_hold: assert property (p_hold) else $error("answer changed");
	property p_qlat; query_done |-> $past(query_valid, 2); endproperty
	a_qlat: assert property (p_qlat) else $error("query latency");
	property p_qbit; query_done |-> query_locked == query_area_bits[bit2_q];
	endproperty
	a_qbit: assert property (p_qbit) else $error("query bit map");
	property p_grant;
		mbw_grant |-> mbw_header_bits[6:1] == lock_cmd_pkg::CMD_WRITE_MULTI;
	endproperty
	a_grant: assert property (p_grant) else $error("grant header");
	c_ok: cover property (resp_valid && !resp_error_flag);
	c_err: cover property (resp_valid && resp_error_flag);
	c_grant: cover property (mbw_grant);
endmodule : lock_handler_chk
bind tag_block_lock_command_handler lock_handler_chk #(
	.LOCK_SUPPORTED(LOCK_SUPPORTED)
) u_lock_handler_chk (.clk(clk), .reset(reset), .rx_frame_end(rx_frame_end),
	.crc16_ok(crc16_ok), .nvm_fail(nvm_fail), .query_valid(query_valid),
	.query_block(query_block), .resp_valid(resp_valid),
	.resp_error_flag(resp_error_flag), .resp_error_code(resp_error_code),
	.mbw_grant(mbw_grant), .mbw_header_bits(mbw_header_bits),
	.query_done(query_done), .query_locked(query_locked),
	.query_area_bits(query_area_bits));
`default_nettype wire

// ===== tb/reader_model.sv
`timescale 1ns/1ns
`default_nettype none
module reader_model (
	// Clock
	input wire logic clk,
	// Frame bits and CRC verdicts
	output logic rx_bit_valid,
	output logic rx_bit,
	output logic rx_frame_end,
	output logic crc5_ok,
	output logic crc16_ok
);
	initial begin
		rx_bit_valid = 1'b0;
		rx_bit = 1'b0;
		rx_frame_end = 1'b0;
		crc5_ok = 1'b1;
		crc16_ok = 1'b1;
	end
	task automatic send(input logic [15:0] h, input logic [39:0] id,
		input logic [31:0] d, input logic [1:0] ok);
		logic [103:0] f;
		int n;
		f = h[8] ? {h, id, d, 16'hA5C3} : {h, d, 16'hA5C3, 40'h0};
		n = h[8] ? 104 : 64;
		crc5_ok = ok[1];
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			rx_bit_valid = 1'b1;
			rx_bit = f[103 - i];
		end
		@(negedge clk);
		rx_bit_valid = 1'b0;
		rx_bit = ~rx_bit;
		rx_frame_end = 1'b1;
		crc16_ok = ok[0];
		@(negedge clk);
		rx_frame_end = 1'b0;
		crc16_ok = 1'b1;
		crc5_ok = 1'b1;
	endtask : send
endmodule : reader_model
`default_nettype wire

// ===== tb/tag_block_lock_command_handler_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
	fail_count++; $display("Error %s exp %0h got %0h", n, e, s); end end
module tag_block_lock_command_handler_tb_top;
	logic clk, reset, rx_bit_valid, rx_bit, rx_frame_end, crc5_ok, crc16_ok;
	logic nvm_fail, resp_valid, resp_error_flag, mbw_grant, query_valid;
	logic query_done, query_locked;
	logic [39:0] uid;
	logic [7:0] resp_error_code, mbw_header_bits, query_block;
	logic [31:0] query_area_bits;
	lock_cmd_pkg::tag_state_e tag_state;
	lock_cmd_pkg::tag_state_e sts [4] = '{lock_cmd_pkg::TAG_READY,
		lock_cmd_pkg::TAG_QUIET, lock_cmd_pkg::TAG_ROUND_ACTIVE,
		lock_cmd_pkg::TAG_ROUND_STANDBY};
	int fail_count, check_count, n_resp, n_grant, m0;
	logic ns_valid, ns_flag;
	logic [7:0] ns_code;
	int n_ns;
	localparam logic [5:0] LK = lock_cmd_pkg::CMD_LOCK_BLOCKS;
	tag_block_lock_command_handler u_tag_block_lock_command_handler (
		.clk(clk), .reset(reset), .rx_bit_valid(rx_bit_valid),
		.rx_bit(rx_bit), .rx_frame_end(rx_frame_end), .crc5_ok(crc5_ok),
		.crc16_ok(crc16_ok), .tag_unique_identifier(uid),
		.tag_state(tag_state), .nvm_fail(nvm_fail), .resp_valid(resp_valid),
		.resp_error_flag(resp_error_flag), .resp_error_code(resp_error_code),
		.mbw_grant(mbw_grant), .mbw_header_bits(mbw_header_bits),
		.query_valid(query_valid), .query_block(query_block),
		.query_done(query_done), .query_locked(query_locked),
		.query_area_bits(query_area_bits));
	tag_block_lock_command_handler #(
		.LOCK_SUPPORTED(1'b0)
	) u_tag_block_lock_command_handler_nosup (
		.clk(clk), .reset(reset), .rx_bit_valid(rx_bit_valid),
		.rx_bit(rx_bit), .rx_frame_end(rx_frame_end), .crc5_ok(crc5_ok),
		.crc16_ok(crc16_ok), .tag_unique_identifier(uid),
		.tag_state(tag_state), .nvm_fail(nvm_fail), .resp_valid(ns_valid),
		.resp_error_flag(ns_flag), .resp_error_code(ns_code),
		.mbw_grant(), .mbw_header_bits(),
		.query_valid(query_valid), .query_block(query_block),
		.query_done(), .query_locked(), .query_area_bits());
	reader_model u_reader_model (.clk(clk), .rx_bit_valid(rx_bit_valid),
		.rx_bit(rx_bit), .rx_frame_end(rx_frame_end), .crc5_ok(crc5_ok),
		.crc16_ok(crc16_ok));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(negedge clk) begin
		if (resp_valid === 1'b1) n_resp++;
		if (mbw_grant === 1'b1) n_grant++;
		if (ns_valid === 1'b1) n_ns++;
	end
	function automatic logic [15:0] mk(input logic e, input logic [5:0] c,
		input logic f, input logic [2:0] a);
		return {e, c, f, a, 5'h00};
	endfunction : mk
	task automatic run(input lock_cmd_pkg::tag_state_e st, input logic [15:0] h,
		input logic [39:0] id, input logic [31:0] d, input logic [1:0] ok,
		input int en, input logic [8:0] ef);
		int n0;
		int n1;
		n0 = n_resp;
		n1 = n_ns;
		tag_state = st;
		u_reader_model.send(h, id, d, ok);
		repeat (3) @(negedge clk);
		`CHK("answers", en, n_resp - n0)
		if (en == 1) `CHK("flag code", ef,
			{resp_error_flag, resp_error_code})
		`CHK("unsupported answers", en, n_ns - n1)
		if (en == 1) `CHK("unsupported code", 9'h101,
			{ns_flag, ns_code})
	endtask : run
	task automatic ask(input logic [7:0] b, input logic el,
		input logic [31:0] ea);
		@(negedge clk);
		query_valid = 1'b1;
		query_block = b;
		@(negedge clk);
		query_valid = 1'b0;
		@(negedge clk);
		`CHK("query done", 1'b1, query_done)
		`CHK("query bit", el, query_locked)
		`CHK("query area", ea, query_area_bits)
	endtask : ask
	task automatic give_verdict();
		$display("Checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (100000) @(posedge clk);
		fail_count++;
		give_verdict();
	end
	initial begin
		reset = 1'b1;
		nvm_fail = 1'b0;
		query_valid = 1'b0;
		query_block = 8'h00;
		uid = 40'h5A_C3F0_1E77; // Arbitrary value
		tag_state = lock_cmd_pkg::TAG_SELECTED;
		repeat (8) @(negedge clk);
		reset = 1'b0;
		ask(8'h00, 1'b0, 32'h0);
		run(lock_cmd_pkg::TAG_SELECTED, mk(0, LK, 0, 3), 0, 32'h8000_0001,
			2'h3, 1, 9'h000);
		ask(8'h60, 1'b1, 32'h8000_0001);
		ask(8'h7F, 1'b1, 32'h8000_0001);
		ask(8'h40, 1'b0, 32'h0);
		run(lock_cmd_pkg::TAG_SELECTED, mk(0, LK, 0, 3), 0, 32'h10, 2'h3,
			1, 9'h000);
		ask(8'h64, 1'b1, 32'h8000_0011);
		for (int i = 0; i < 4; i++) begin
			run(sts[i], mk(0, LK, 0, 7), uid, 32'hFFFF_0000, 2'h3, 0, 0);
			run(sts[i], mk(0, LK, 1, 7), ~uid, 32'hFF00, 2'h3, 0, 0);
			run(sts[i], mk(0, LK, 1, 7), uid, 32'h1 << i, 2'h3, 1, 0);
		end
		ask(8'hE3, 1'b1, 32'hF);
		run(lock_cmd_pkg::TAG_SELECTED, mk(0, LK, 1, 7), ~uid, 32'h8000_0000,
			2'h3, 0, 0);
		run(lock_cmd_pkg::TAG_SELECTED, mk(0, LK, 1, 7), uid, 32'h8000_0000,
			2'h3, 1, 0);
		ask(8'hFF, 1'b1, 32'h8000_000F);
		run(lock_cmd_pkg::TAG_SELECTED, mk(0, LK, 0, 2), 0, '1, 2'h2, 0, 0);
		run(lock_cmd_pkg::TAG_SELECTED, mk(0, LK, 0, 2), 0, '1, 2'h1, 0, 0);
		run(lock_cmd_pkg::TAG_SELECTED, mk(1, LK, 0, 2), 0, '1, 2'h3, 0, 0);
		ask(8'h5F, 1'b0, 32'h0);
		nvm_fail = 1'b1;
		run(lock_cmd_pkg::TAG_SELECTED, mk(0, LK, 0, 1), 0, 32'h1, 2'h3,
			1, 9'h10F);
		nvm_fail = 1'b0;
		m0 = n_grant;
		run(lock_cmd_pkg::TAG_SELECTED, mk(0, lock_cmd_pkg::CMD_WRITE_MULTI, 0,
			0), 0, 32'h1234_5678, 2'h3, 0, 0);
		`CHK("grants", 1, n_grant - m0)
		`CHK("grant hdr", {1'b0, lock_cmd_pkg::CMD_WRITE_MULTI, 1'b0},
			mbw_header_bits)
		run(lock_cmd_pkg::TAG_READY, mk(0, lock_cmd_pkg::CMD_WRITE_MULTI, 1,
			0), ~uid, 32'h0, 2'h3, 0, 0);
		`CHK("grants", 1, n_grant - m0)
		give_verdict();
	end
endmodule : tag_block_lock_command_handler_tb_top
`default_nettype wire
